// File: design/hsc_defines.svh
// timing counts, register indices and field positions for the host serial control port
`ifndef HSC_DEFINES_SVH
`define HSC_DEFINES_SVH

`define HSC_CEIL(a, b)        (((a) + (b) - 1) / (b))

// system clock and device master clock period t, in ns
`define HSC_CLK_NS            4
`define HSC_T_NS              30

// shift clock low and high width: 1t + 20 ns
`define HSC_SWL_NS            (`HSC_T_NS + 20)
`define HSC_HALF_CYC          `HSC_CEIL(`HSC_SWL_NS, `HSC_CLK_NS)
// strobe rise to first data rising edge on a write: 3t + 20 ns
`define HSC_LSD_NS            (3 * `HSC_T_NS + 20)
`define HSC_LSD_CYC           `HSC_CEIL(`HSC_LSD_NS, `HSC_CLK_NS)
// falling edge to read bit valid: 2t + 70 ns, plus synchroniser delay
`define HSC_SDD_NS            (2 * `HSC_T_NS + 70)
`define HSC_RD_TICKS          `HSC_CEIL(`HSC_SDD_NS + 3 * `HSC_CLK_NS, `HSC_SWL_NS)

// section lengths
`define HSC_HDR_BITS          16
`define HSC_COEF_BITS         16
`define HSC_SETUP_BITS        24

// mode byte field positions
`define HSC_MODE_UNMUTE       7
`define HSC_MODE_TSEL_HI      4
`define HSC_MODE_TSEL_LO      3
`define HSC_MODE_DIR          0
// target select codes {hi, lo}
`define HSC_TSEL_SETUP        2'b10
`define HSC_TSEL_COEF         2'b01
// setup bits the host must keep at zero
`define HSC_SETUP_ZERO_MSB    23
`define HSC_SETUP_ZERO_LSB    12

// register word indices
`define HSC_REG_CTRL          3'h0
`define HSC_REG_ADDR          3'h1
`define HSC_REG_WDATA         3'h2
`define HSC_REG_RDATA         3'h3
`define HSC_REG_STATUS        3'h4

// control register fields
`define HSC_CTRL_GO           0
`define HSC_CTRL_READ         1
`define HSC_CTRL_SETUP        2
`define HSC_CTRL_UNMUTE       3

// status register fields
`define HSC_STAT_BUSY         0
`define HSC_STAT_DONE         1
`define HSC_STAT_READY        2

`endif

// File: design/hsc_pkg.sv
// types for the host serial control port
package hsc_pkg;

    typedef enum logic [3:0] {
        HSC_IDLE      = 4'b0000,
        HSC_WAIT_FALL = 4'b0001,
        HSC_LAT_LO    = 4'b0011,
        HSC_HDR_HI    = 4'b0010,
        HSC_HDR_LO    = 4'b0110,
        HSC_WAIT_RDY  = 4'b0111,
        HSC_GAP       = 4'b0101,
        HSC_DAT_LO    = 4'b0100,
        HSC_DAT_HI    = 4'b1100,
        HSC_RD_LOW    = 4'b1101,
        HSC_RD_HIGH   = 4'b1111,
        HSC_RDB_HI    = 4'b1110,
        HSC_RDB_LO    = 4'b1010
    } hsc_state_type;

endpackage

// File: design/hsc_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module hsc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // asynchronous in, synchronised out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    if (W < 1) begin : g_chk
        $error("hsc_sync: W must be at least 1");
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// File: design/hsc_tick.sv
// enable pulse divider for shift clock half periods
`timescale 1ns/100ps
module hsc_tick #(
    parameter int DIV = 13
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // run restarts the count from zero when it rises
    input  wire logic run_i,
    output logic      tick_o
);
    logic [15:0] cnt_q;

    if (DIV < 1 || DIV > 65535) begin : g_chk
        $error("hsc_tick: DIV out of range");
    end

    assign tick_o = run_i && (cnt_q == 16'(DIV - 1));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_i || tick_o) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule

// File: design/hsc_ctrl.sv
// host controller for the serial control port, with an avalon-mm register slave
// What this block does
// - address, mode and data sections all travel least significant bit first.
// - coefficient data section is 16 shift cycles, setup register is 24.
// - ready is open drain; low forbids transfers, released high allows them.
// - host waits for ready high before raising the next latch strobe.
// - on writes host waits 3t plus 20 ns before first data edge.
// - after a write host may start shifting once ready is low.
// - host always waits on ready; it has no fallback spacing for use without ready.
// - read bits follow ready high, one per falling edge, sampled at rise.
// - after a read host lowers next strobe without waiting for a ready fall; only a write leaves one pending.
// - next address and mode shift only after read data shifting has ended.
// - host keeps setup register bits 23 to 12 at zero.
`timescale 1ns/100ps
`include "hsc_defines.svh"
module hsc_ctrl #(
    parameter int HALF_CYC = `HSC_HALF_CYC,
    parameter int LSD_CYC  = `HSC_LSD_CYC,
    parameter int RD_TICKS = `HSC_RD_TICKS
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // avalon-mm slave
    input  wire logic [2:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // device control pins
    output logic             sck_o,
    output logic             host_serial_in_o,
    output logic             latch_strobe_n_o,
    input  wire logic        host_serial_out_i,
    input  wire logic        transfer_ready_i
);
    import hsc_pkg::*;

    if (HALF_CYC < 1 || LSD_CYC < 1 || RD_TICKS < 1 || RD_TICKS > 255) begin : g_chk
        $error("hsc_ctrl: timing parameters out of range");
    end

    function automatic logic [4:0] hsc_len(input logic setup);
        hsc_len = setup ? 5'(`HSC_SETUP_BITS) : 5'(`HSC_COEF_BITS);
    endfunction

    hsc_state_type state_q;
    logic          ack_q;
    logic          rd_q;
    logic          setup_q;
    logic          unmute_q;
    logic [7:0]    addr_q;
    logic [23:0]   wdata_q;
    logic [23:0]   rdata_q;
    logic          done_q;
    logic          need_fall_q;
    logic [23:0]   sh_q;
    logic [23:0]   rsh_q;
    logic [23:0]   rsh_d;
    logic [4:0]    cnt_q;
    logic [7:0]    sub_q;
    logic [15:0]   gap_q;
    logic [1:0]    pins_s;
    logic          ready_s;
    logic          sdo_s;
    logic          run;
    logic          tick;
    logic          go;
    logic          busy;
    logic          last_bit;
    logic [7:0]    mode;
    logic [23:0]   wsec;

    // ready only sampled
    // pins from the device pass two flops before use
    hsc_sync #(
        .W (2)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({transfer_ready_i, host_serial_out_i}),
        .sync_o  (pins_s)
    );
    assign ready_s = pins_s[1];
    assign sdo_s   = pins_s[0];

    assign run = (state_q == HSC_LAT_LO) || (state_q == HSC_HDR_HI) || (state_q == HSC_HDR_LO)
              || (state_q == HSC_WAIT_RDY) || (state_q == HSC_DAT_LO) || (state_q == HSC_DAT_HI)
              || (state_q == HSC_RDB_HI) || (state_q == HSC_RDB_LO);

    hsc_tick #(
        .DIV (HALF_CYC)
    ) u_tick (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .run_i   (run),
        .tick_o  (tick)
    );

    // register slave: one wait cycle, answer on the second
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    assign busy = (state_q != HSC_IDLE);
    assign go   = avs_write_i && ack_q && (avs_address_i == `HSC_REG_CTRL)
               && avs_writedata_i[`HSC_CTRL_GO] && !busy;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
        end
    end

    // configuration is frozen while a transfer runs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_q     <= 1'b0;
            setup_q  <= 1'b0;
            unmute_q <= 1'b0;
            addr_q   <= 8'h00;
            wdata_q  <= 24'h00_0000;
        end else if (avs_write_i && ack_q && !busy) begin
            unique case (avs_address_i)
                `HSC_REG_CTRL: begin
                    rd_q     <= avs_writedata_i[`HSC_CTRL_READ];
                    setup_q  <= avs_writedata_i[`HSC_CTRL_SETUP];
                    unmute_q <= avs_writedata_i[`HSC_CTRL_UNMUTE];
                end
                `HSC_REG_ADDR:  addr_q  <= avs_writedata_i[7:0];
                `HSC_REG_WDATA: wdata_q <= avs_writedata_i[23:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            unique case (avs_address_i)
                `HSC_REG_CTRL:   avs_readdata_o <= {28'h000_0000, unmute_q, setup_q, rd_q, 1'b0};
                `HSC_REG_ADDR:   avs_readdata_o <= {24'h00_0000, addr_q};
                `HSC_REG_WDATA:  avs_readdata_o <= {8'h00, wdata_q};
                `HSC_REG_RDATA:  avs_readdata_o <= {8'h00, rdata_q};
                `HSC_REG_STATUS: avs_readdata_o <= {29'h0000_0000, ready_s, done_q, busy};
                default:         avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // mode byte: mute, target select, direction
    always_comb begin
        mode = 8'h00;
        mode[`HSC_MODE_UNMUTE] = unmute_q;
        {mode[`HSC_MODE_TSEL_HI], mode[`HSC_MODE_TSEL_LO]} = setup_q ? `HSC_TSEL_SETUP : `HSC_TSEL_COEF;
        mode[`HSC_MODE_DIR] = rd_q;
    end

    always_comb begin
        wsec = wdata_q;
        if (setup_q) begin
            wsec[`HSC_SETUP_ZERO_MSB:`HSC_SETUP_ZERO_LSB] = 12'h000;
        end else begin
            wsec[23:16] = 8'h00;
        end
    end

    assign last_bit = (cnt_q == hsc_len(setup_q) - 5'd1);
    assign rsh_d    = {sdo_s, rsh_q[23:1]};

    // write leaves a pending ready fall
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            need_fall_q <= 1'b0;
        end else if (state_q == HSC_DAT_HI && tick && last_bit) begin
            need_fall_q <= 1'b1;
        end else if (!ready_s) begin
            need_fall_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q          <= HSC_IDLE;
            sck_o            <= 1'b0;
            latch_strobe_n_o <= 1'b1;
            host_serial_in_o <= 1'b0;
            sh_q             <= 24'h00_0000;
            rsh_q            <= 24'h00_0000;
            rdata_q          <= 24'h00_0000;
            cnt_q            <= 5'd0;
            sub_q            <= 8'h00;
            gap_q            <= 16'h0000;
            done_q           <= 1'b0;
        end else begin
            unique case (state_q)
                HSC_IDLE: begin
                    if (go) begin
                        done_q  <= 1'b0;
                        state_q <= HSC_WAIT_FALL;
                    end
                end
                // strobe falls only once any ready fall pending after a write was seen
                HSC_WAIT_FALL: begin
                    if (!need_fall_q) begin
                        latch_strobe_n_o <= 1'b0;
                        sh_q             <= {8'h00, mode, addr_q};
                        host_serial_in_o <= addr_q[0];
                        cnt_q            <= 5'd0;
                        state_q          <= HSC_LAT_LO;
                    end
                end
                HSC_LAT_LO, HSC_HDR_LO: begin
                    if (tick) begin
                        sck_o   <= 1'b1;
                        state_q <= HSC_HDR_HI;
                    end
                end
                HSC_HDR_HI: begin
                    if (tick) begin
                        sck_o <= 1'b0;
                        if (cnt_q == 5'(`HSC_HDR_BITS - 1)) begin
                            host_serial_in_o <= 1'b0;
                            state_q          <= HSC_WAIT_RDY;
                        end else begin
                            sh_q             <= {1'b0, sh_q[23:1]};
                            host_serial_in_o <= sh_q[1];
                            cnt_q            <= cnt_q + 5'd1;
                            state_q          <= HSC_HDR_LO;
                        end
                    end
                end
                // strobe rises only with ready high
                HSC_WAIT_RDY: begin
                    if (tick && ready_s) begin
                        latch_strobe_n_o <= 1'b1;
                        gap_q            <= 16'h0000;
                        state_q          <= rd_q ? HSC_RD_LOW : HSC_GAP;
                    end
                end
                // wait before first write data edge
                HSC_GAP: begin
                    gap_q <= gap_q + 16'h0001;
                    if (gap_q == 16'(LSD_CYC - 1)) begin
                        sh_q             <= wsec;
                        host_serial_in_o <= wsec[0];
                        cnt_q            <= 5'd0;
                        state_q          <= HSC_DAT_LO;
                    end
                end
                HSC_DAT_LO: begin
                    if (tick) begin
                        sck_o   <= 1'b1;
                        state_q <= HSC_DAT_HI;
                    end
                end
                HSC_DAT_HI: begin
                    if (tick) begin
                        sck_o <= 1'b0;
                        if (last_bit) begin
                            host_serial_in_o <= 1'b0;
                            done_q           <= 1'b1;
                            state_q          <= HSC_IDLE;
                        end else begin
                            sh_q             <= {1'b0, sh_q[23:1]};
                            host_serial_in_o <= sh_q[1];
                            cnt_q            <= cnt_q + 5'd1;
                            state_q          <= HSC_DAT_LO;
                        end
                    end
                end
                HSC_RD_LOW: begin
                    if (!ready_s) begin
                        state_q <= HSC_RD_HIGH;
                    end
                end
                // shifting starts after ready returns high
                HSC_RD_HIGH: begin
                    if (ready_s) begin
                        sck_o   <= 1'b1;
                        cnt_q   <= 5'd0;
                        state_q <= HSC_RDB_HI;
                    end
                end
                HSC_RDB_HI: begin
                    if (tick) begin
                        sck_o   <= 1'b0;
                        sub_q   <= 8'h00;
                        state_q <= HSC_RDB_LO;
                    end
                end
                // sample late in the low phase, just before the rise
                HSC_RDB_LO: begin
                    if (tick) begin
                        sub_q <= sub_q + 8'h01;
                        if (sub_q == 8'(RD_TICKS - 1)) begin
                            rsh_q <= rsh_d;
                            if (last_bit) begin
                                rdata_q <= setup_q ? rsh_d : {8'h00, rsh_d[23:8]};
                                done_q  <= 1'b1;
                                state_q <= HSC_IDLE;
                            end else begin
                                sck_o   <= 1'b1;
                                cnt_q   <= cnt_q + 5'd1;
                                state_q <= HSC_RDB_HI;
                            end
                        end
                    end
                end
                default: state_q <= HSC_IDLE;
            endcase
        end
    end

    // helper counters read only by assertions
    logic [5:0]  rises_q;
    logic [15:0] len_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || $fell(latch_strobe_n_o)) begin
            rises_q <= 6'd0;
        end else if ($rose(sck_o)) begin
            rises_q <= rises_q + 6'd1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || (sck_o != $past(sck_o))) begin
            len_q <= 16'h0000;
        end else if (len_q != 16'hffff) begin
            len_q <= len_q + 16'h0001;
        end
    end

    a_strobe_rise_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(latch_strobe_n_o) |-> $past(ready_s))
        else $error("latch strobe rose while ready was low");

    a_header_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(latch_strobe_n_o) |-> rises_q == 6'd16)
        else $error("header did not carry 16 shift edges");

    a_data_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(done_q) && !rd_q |-> rises_q == 6'd16 + 6'(hsc_len(setup_q)))
        else $error("write data section length wrong");

    a_lsb_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(latch_strobe_n_o) |-> host_serial_in_o == addr_q[0] ##1 host_serial_in_o == addr_q[0])
        else $error("address lsb not presented first");

    a_write_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(sck_o) && state_q == HSC_DAT_HI && cnt_q == 5'd0 |-> gap_q >= 16'(LSD_CYC))
        else $error("first write data edge too soon after strobe");

    a_phase_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sck_o != $past(sck_o)) |-> len_q >= 16'(HALF_CYC - 1))
        else $error("shift clock phase too short");

    a_fall_after_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(latch_strobe_n_o) |-> !$past(need_fall_q))
        else $error("strobe lowered before ready fall after write");

    a_setup_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_q == HSC_DAT_LO && setup_q && cnt_q == 5'd0 |-> sh_q[23:12] == 12'h000)
        else $error("reserved setup bits not zero");

    a_read_after_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(sck_o) && state_q == HSC_RDB_HI && cnt_q == 5'd0 |-> $past(ready_s))
        else $error("read shifting began without ready high");
endmodule

// File: dv/hsc_dev_model.sv
// behavioural model of the serial control device behind the controller
`timescale 1ns/100ps
module hsc_dev_model #(
    parameter int SLOT_CYC = 40,
    parameter int HOLD_CYC = 60
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sck_i,
    input  wire logic        sdi_i,
    input  wire logic        strobe_n_i,
    output logic             sdo_o,
    output logic             sdo_oe_o,
    output logic             rdy_low_o,
    output logic [7:0]       mode_o,
    output logic [7:0]       addr_o,
    output logic [31:0]      viol_o
);
    logic        sck_q, stb_q;
    logic [39:0] sr_q;
    logic [23:0] setup_q, rd_q, wd_q;
    logic [15:0] coef_q [192];
    logic [1:0]  ph_q;
    int          nbit_q, cnt_q, k_q, lsd_q, len;
    assign len = mode_o[4] ? 24 : 16;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            {sck_q, stb_q, sdo_o, sdo_oe_o, rdy_low_o, ph_q} <= 7'h0;
            stb_q <= 1'b1;
            viol_o <= 32'h0000_0000;
            setup_q <= 24'h00_0000;
            for (int i = 0; i < 192; i++) coef_q[i] <= 16'h0000;
        end else begin
            sck_q <= sck_i;
            stb_q <= strobe_n_i;
            lsd_q <= lsd_q + 1;
            cnt_q <= cnt_q + 1;
            if (sck_i && !sck_q) begin
                sr_q <= {sdi_i, sr_q[39:1]};
                nbit_q <= nbit_q + 1;
                // first write data edge after 3t plus 20 ns, counted in whole clocks
                if (ph_q == 2'd1 && nbit_q == 0 && lsd_q < 28) viol_o <= viol_o + 1;
            end
            // header decoded on own strobe rise
            if (strobe_n_i && !stb_q) begin
                // strobe must not rise while ready is low
                if (rdy_low_o) viol_o <= viol_o + 1;
                {mode_o, addr_o} <= sr_q[39:24];
                {nbit_q, lsd_q, cnt_q} <= '0;
                ph_q <= sr_q[32] ? 2'd2 : 2'd1;
            end
            // write ends after 16 or 24 data bits
            if (ph_q == 2'd1 && nbit_q == len) begin
                ph_q <= 2'd2;
                cnt_q <= 0;
                // hold the data now: the next header may shift in before the slot
                wd_q <= mode_o[4] ? sr_q[39:16] : {8'h00, sr_q[39:24]};
            end
            if (ph_q == 2'd2 && cnt_q == 2) begin
                rdy_low_o <= 1'b1;
                sdo_oe_o <= mode_o[0];
                sdo_o <= 1'b0;
            end
            // commit in update slot, then release
            if (ph_q == 2'd2 && cnt_q == SLOT_CYC) begin
                rdy_low_o <= 1'b0;
                rd_q <= mode_o[4] ? setup_q : {8'h00, coef_q[addr_o]};
                ph_q <= mode_o[0] ? 2'd3 : 2'd0;
                k_q <= 0;
                if (!mode_o[0] && mode_o[4:3] == 2'b10) setup_q <= wd_q;
                if (!mode_o[0] && mode_o[4:3] == 2'b01 && addr_o < 192) coef_q[addr_o] <= wd_q[15:0];
            end
            // next read bit on each falling edge
            if (ph_q == 2'd3 && !sck_i && sck_q && k_q < len) begin
                sdo_o <= rd_q[k_q];
                k_q <= k_q + 1;
                cnt_q <= 0;
            end
            // float once the last bit has been held
            if (ph_q == 2'd3 && k_q == len && cnt_q == HOLD_CYC) begin
                sdo_oe_o <= 1'b0;
                ph_q <= 2'd0;
            end
        end
    end
endmodule

// File: dv/host_serial_control_port_tb_top.sv
// self-checking bench for the host serial control port controller
`timescale 1ns/100ps
module host_serial_control_port_tb_top;
    logic        clk_i, rst_n_i, avs_read, avs_write;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata_o, viol, q, rng;
    logic        avs_waitrequest_o, sck, sdi, stb_n, sdo, sdo_oe, rdy_low;
    logic [7:0]  dev_mode, dev_addr, a;
    logic [15:0] bcoef [192];
    logic [23:0] bsetup;
    int          miscompares, n_compared;
    tri1         sdo_w, rdy_w;
    // pull-ups stand in for the open-drain and floating lines
    assign sdo_w = sdo_oe ? sdo : 1'bz;
    assign rdy_w = rdy_low ? 1'b0 : 1'bz;
    hsc_ctrl u_hsc_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .sck_o(sck), .host_serial_in_o(sdi), .latch_strobe_n_o(stb_n),
        .host_serial_out_i(sdo_w), .transfer_ready_i(rdy_w));
    hsc_dev_model u_hsc_dev_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .sdi_i(sdi), .strobe_n_i(stb_n),
        .sdo_o(sdo), .sdo_oe_o(sdo_oe), .rdy_low_o(rdy_low), .mode_o(dev_mode), .addr_o(dev_addr), .viol_o(viol));
    always #2 clk_i = ~clk_i;
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one avalon access; request held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [2:0] ad, input logic [31:0] d, output logic [31:0] r);
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        r = avs_readdata_o;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            av(1'b0, 3'h4, 32'h0, q);
            n++;
        end while ((q & m) !== v && n < 3000);
        if ((q & m) !== v) begin
            miscompares++;
            wrap_up();
        end
    endtask
    task automatic xfer(input logic rd, input logic st, input logic um, input logic [23:0] d);
        av(1'b1, 3'h1, {24'h0, a}, q);
        av(1'b1, 3'h2, {8'h0, d}, q);
        av(1'b1, 3'h0, {28'h0, um, st, rd, 1'b1}, q);
        // busy refuses register writes
        av(1'b1, 3'h1, {24'h0, ~a}, q);
        wait_st(32'h3, 32'h2);
        chk("mode", dev_mode, {um, 2'b00, st, ~st, 2'b00, rd});
        chk("addr", dev_addr, a);
        av(1'b0, 3'h1, 32'h0, q);
        chk("addr_reg", q, a);
        if (rd) begin
            av(1'b0, 3'h3, 32'h0, q);
            chk("rdata", q, st ? {8'h0, bsetup} : {16'h0, bcoef[a]});
        end else if (st) bsetup = d & 24'h00_0fff;
        else bcoef[a] = d[15:0];
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        miscompares++;
        wrap_up();
    end
    initial begin
        {clk_i, rst_n_i, avs_read, avs_write, avs_address, avs_writedata} = '0;
        rng = 32'h34ea_86e6;
        bsetup = 24'h00_0000;
        a = 8'h00;
        for (int i = 0; i < 192; i++) bcoef[i] = 16'h0000;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        av(1'b0, 3'h0, 32'h0, q);
        chk("ctrl", q, 32'h0);
        av(1'b0, 3'h5, 32'h0, q);
        chk("unmapped", q, 32'h0);
        // ready needs the two synchroniser flops before status shows it
        av(1'b0, 3'h4, 32'h0, q);
        chk("status", q, 32'h4);
        for (int i = 0; i < 12; i++) begin
            void'(xs());
            if (i % 4 == 0) a = (i == 4) ? 8'd191 : (i == 0) ? 8'd0 : 8'(rng[15:8] % 8'd192);
            xfer(i % 4 >= 2, i[0], rng[0], rng[31:8]);
        end
        wait_st(32'h4, 32'h4);
        for (int i = 0; i < 192; i++) chk("coef", u_hsc_dev_model.coef_q[i], bcoef[i]);
        chk("setup", u_hsc_dev_model.setup_q, bsetup);
        chk("viol", viol, 32'h0);
        wrap_up();
    end
endmodule
